/* hdl/sfep_pkg.sv */
/*
  sfep_pkg: shared constants of the serial flash erase/program engine.
  assumes a 250 MHz system clock and a host-made serial clock.
*/
package sfep_pkg;
  localparam int             CLK_PERIOD_NS  = 4;
  localparam int             SCLK_PERIOD_NS = 125;
  localparam logic [7:0]     SCLK_HALF_CYC  = 8'((SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
  // self-timed cycle times, microseconds
  localparam int             SE_TIME_US     = 40_000;
  localparam int             BE_TIME_US     = 700_000;
  localparam int             CE_TIME_US     = 4_000_000;
  localparam int             PP_TIME_US     = 1_400;
  localparam int             BP_TIME_US     = 10;
  // opcodes given by the command set
  localparam logic [7:0]     OPC_CP         = 8'h00AD;
  localparam logic [7:0]     OPC_WRITE_DISABLE_CMD       = 8'h0004;
  localparam logic [7:0]     OPC_STATUS_READ_CMD       = 8'h0005;
  localparam logic [7:0]     OPC_SECURITY_READ_CMD     = 8'h002B;
  // opcode defaults for the design parameters
  localparam logic [7:0]     DEF_OPC_WRITE_ENABLE_CMD   = 8'h0006;
  localparam logic [7:0]     DEF_OPC_SE     = 8'h0020;
  localparam logic [7:0]     DEF_OPC_BE     = 8'h00D8;
  localparam logic [7:0]     DEF_OPC_CE     = 8'h0060;
  localparam logic [7:0]     DEF_OPC_PP     = 8'h0002;
  localparam logic [7:0]     DEF_OPC_QPP    = 8'h0038;
  localparam logic [7:0]     DEF_OPC_BUSY_ON_OUTPUT_ON_CMD   = 8'h0070;
  localparam logic [7:0]     DEF_OPC_BUSY_ON_OUTPUT_OFF_CMD   = 8'h0080;
  // address layout
  localparam int             ADDR_W         = 24;
  localparam int             ARRAY_W        = 21;
  localparam int             BLOCK_LSB      = 16;
  localparam int             SECTOR_LSB     = 12;
  localparam int             PAGE_LSB       = 8;
  localparam logic [5:0]     NUM_BLOCKS     = 6'h0020;
  // frame lengths in bits; page and continuous program lengths in bytes
  localparam logic [15:0]    BITS_OPC       = 16'h0008;
  localparam logic [15:0]    BITS_CP_SHORT  = 16'h0018;
  localparam logic [15:0]    BITS_ADDR      = 16'h0020;
  localparam logic [15:0]    BITS_PP_MIN    = 16'h0028;
  localparam logic [15:0]    BITS_CP_LONG   = 16'h0030;
  localparam logic [8:0]     PAGE_BYTES     = 9'h0100;
  localparam logic [8:0]     CP_BYTES       = 9'h0002;
  // status and security bit positions
  localparam int             ST_WIP         = 0;
  localparam int             ST_WEL         = 1;
  localparam int             ST_BP_LSB      = 2;
  localparam int             ST_QE          = 6;
  localparam int             SEC_CP         = 4;

  typedef enum logic [1:0] {
    SFEP_OP_SECTOR = 2'b00,
    SFEP_OP_BLOCK  = 2'b01,
    SFEP_OP_CHIP   = 2'b10,
    SFEP_OP_PROG   = 2'b11
  } sfep_op_t;

  // sector and block protection from the protect level bits
  function automatic logic sfep_protected(input logic [ADDR_W-1:0] a, input logic [3:0] lvl);
    logic [3:0] sh;
    logic [5:0] n;
    sh = lvl - 4'h1;
    n  = 6'h01 << sh[2:0];
    return (lvl != 4'h0) && ((sh >= 4'h5) || ({1'b0, a[ARRAY_W-1:BLOCK_LSB]} >= NUM_BLOCKS - n));
  endfunction
endpackage

/* hdl/sfep_if.sv */
/*
  sfep_if: serial flash link between host and device ends.
  assumes each end gives output enables; undriven lines pull high.
*/
`timescale 1ns/1ps
interface sfep_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io;
  logic [3:0] host_io_oe_n;
  logic [3:0] dev_io;
  logic [3:0] dev_io_oe_n;
  logic [3:0] io;

  // wire level from enables, pull-up when idle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = !dev_io_oe_n[i] ? dev_io[i] : (!host_io_oe_n[i] ? host_io[i] : 1'b1);
    end
  end

  modport host (output cs_n, sclk, host_io, host_io_oe_n, input io);
  modport dev  (input cs_n, sclk, io, output dev_io, dev_io_oe_n);
endinterface

/* hdl/sfep_flash_dev.sv */
/*
  sfep_flash_dev: device end, erase/program command engine.
  assumes the host drives cs_n, sclk and io lines; the array lives outside
  and applies the op stream (program ands the byte in, erase sets ones).
*/
// Functional notes
// - sector erase: 4K sector, needs write latch
// - sector erase: opcode, 3 address bytes, exact end
// - sector chosen by address bits down to 12
// - erase starts at cs rise, flag, latch cleared
// - protected sector is never erased
// - block erase: 64K, same framing, protected refused
// - chip erase: opcode only, byte-exact end
// - chip erase only with protect level zero
// - chip erase timed, flag, latch cleared after
// - page program wraps inside 256-byte page
// - last 256 bytes kept, others untouched
// - page program ends exactly on data byte
// - program timed from cs rise, protected skipped
// - quad program needs quad enable, four lines
// - host keeps quad clock below 50MHz
// - continuous program: two bytes, even then odd
// - one byte does nothing, extras ignored
// - protected continuous target ignored, latch kept
// - no wrap; end of area exits, latch cleared
// - continuous mode limits commands, disable when idle
// - host ends mode with write disable
// - ready/busy on output when enabled before
`timescale 1ns/1ps
module sfep_flash_dev
  import sfep_pkg::*;
#(
  parameter logic [7:0]  OPC_WRITE_ENABLE_CMD  = DEF_OPC_WRITE_ENABLE_CMD,
  parameter logic [7:0]  OPC_SE    = DEF_OPC_SE,
  parameter logic [7:0]  OPC_BE    = DEF_OPC_BE,
  parameter logic [7:0]  OPC_CE    = DEF_OPC_CE,
  parameter logic [7:0]  OPC_PP    = DEF_OPC_PP,
  parameter logic [7:0]  OPC_QPP   = DEF_OPC_QPP,
  parameter logic [7:0]  OPC_BUSY_ON_OUTPUT_ON_CMD  = DEF_OPC_BUSY_ON_OUTPUT_ON_CMD,
  parameter logic [7:0]  OPC_BUSY_ON_OUTPUT_OFF_CMD  = DEF_OPC_BUSY_ON_OUTPUT_OFF_CMD,
  parameter logic [31:0] SE_CYC    = 32'(64'(SE_TIME_US) * 64'd1000 / 64'(CLK_PERIOD_NS)),
  parameter logic [31:0] BE_CYC    = 32'(64'(BE_TIME_US) * 64'd1000 / 64'(CLK_PERIOD_NS)),
  parameter logic [31:0] CE_CYC    = 32'(64'(CE_TIME_US) * 64'd1000 / 64'(CLK_PERIOD_NS)),
  parameter logic [31:0] PP_CYC    = 32'(64'(PP_TIME_US) * 64'd1000 / 64'(CLK_PERIOD_NS))
) (
  // system
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  // link
  sfep_if.dev                    lnk,
  // status inputs
  input  wire logic [3:0]        protect_level_bits_in,
  input  wire logic              quad_lines_enable_in,
  // array operations
  output logic                   op_valid_out,
  output sfep_op_t               op_kind_out,
  output logic [ADDR_W-1:0]      op_addr_out,
  output logic [7:0]             op_data_out,
  // state
  output logic                   in_progress_flag_out,
  output logic                   write_latch_out,
  output logic                   cp_mode_out
);
  localparam logic [31:0] BP_CYC = 32'(BP_TIME_US * 1000 / CLK_PERIOD_NS);

  typedef struct packed {
    logic [15:0]       bits;
    logic [7:0]        sh;
    logic [7:0]        opc;
    logic [ADDR_W-1:0] addr;
    logic [9:0]        dcnt;
    logic [7:0]        d0;
    logic [7:0]        d1;
    logic [255:0]      mask;
    logic [8:0]        sy1;
    logic [8:0]        sy2;
  } sfep_lnk_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EMIT = 2'b01,
    ST_WAIT = 2'b11
  } sfep_dst_t;

  typedef struct packed {
    sfep_dst_t         st;
    logic              write_latch;
    logic              busy;
    logic              cp;
    logic              ryby;
    sfep_op_t          kind;
    logic [31:0]       timer;
    logic [8:0]        idx;
    logic [8:0]        lim;
    logic [ADDR_W-1:0] base;
    logic              op_v;
    sfep_op_t          op_k;
    logic [ADDR_W-1:0] op_a;
    logic [7:0]        op_d;
    logic [2:0]        cs_sy;
  } sfep_ref_t;

  sfep_lnk_t         l_r, l_nxt;
  sfep_ref_t         r_r, r_nxt;
  logic [7:0]        pbuf [256];
  logic              fresh_r;
  logic              so_r;
  logic              so_oe_n_r;
  logic              wr_en;
  logic [7:0]        wr_idx;
  logic [7:0]        status_s;
  logic [7:0]        secur_s;

  // link side: busy, wel, cp, ryby, qe, protect level
  wire        busy_s = l_r.sy2[8];
  wire        cp_s   = l_r.sy2[6];
  wire        ryby_s = l_r.sy2[5];
  wire        qe_s   = l_r.sy2[4];

  // frame start marker, set while cs_n is high
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_comb begin
    logic [15:0] b0;
    logic [15:0] b1;
    logic [15:0] hdr;
    logic [9:0]  dc0;
    logic        wide;
    logic [7:0]  shn;
    b0     = fresh_r ? '0 : l_r.bits;
    dc0    = fresh_r ? '0 : l_r.dcnt;
    l_nxt  = l_r;
    l_nxt.mask = fresh_r ? '0 : l_r.mask;
    l_nxt.sy1  = {r_r.busy, r_r.write_latch, r_r.cp, r_r.ryby, quad_lines_enable_in, protect_level_bits_in};
    l_nxt.sy2  = l_r.sy1;
    wide   = (l_r.opc == OPC_QPP) && qe_s && (b0 >= BITS_OPC);
    // later continuous frames carry no address
    hdr    = (l_r.opc == OPC_CP && cp_s) ? BITS_OPC : BITS_ADDR;
    shn    = wide ? {l_r.sh[3:0], lnk.io} : {l_r.sh[6:0], lnk.io[0]};
    b1     = b0 + (wide ? 16'h0004 : 16'h0001);
    wr_en  = 1'b0;
    // buffer index wraps within the page
    wr_idx = l_r.addr[7:0] + dc0[7:0];
    l_nxt.sh   = shn;
    l_nxt.bits = b1;
    l_nxt.dcnt = dc0;
    if (b1[2:0] == 3'h0) begin
      if (b1 == BITS_OPC) begin
        l_nxt.opc = shn;
      end else if (b1 <= hdr) begin
        l_nxt.addr = {l_r.addr[15:0], shn};
      end else begin
        wr_en = 1'b1;
        l_nxt.mask[wr_idx] = 1'b1;
        // only the first two bytes kept
        if (dc0 == 10'h000) begin
          l_nxt.d0 = shn;
        end
        if (dc0 == 10'h001) begin
          l_nxt.d1 = shn;
        end
        if (dc0 != 10'h3FF) begin
          l_nxt.dcnt = dc0 + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge lnk.sclk) begin
    l_r <= l_nxt;
  end

  always_ff @(posedge lnk.sclk) begin
    if (wr_en) begin
      pbuf[wr_idx] <= l_nxt.sh;
    end
  end

  assign status_s = {1'b0, qe_s, l_r.sy2[3:0], l_r.sy2[7], busy_s};
  assign secur_s  = 8'(cp_s) << SEC_CP;

  // serial output on falling sclk, released while cs_n high
  always_ff @(negedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      so_r      <= 1'b1;
      so_oe_n_r <= 1'b1;
    end else if (l_r.bits >= BITS_OPC && l_r.opc == OPC_STATUS_READ_CMD) begin
      so_r      <= status_s[3'h7 - l_r.bits[2:0]];
      so_oe_n_r <= 1'b0;
    end else if (l_r.bits >= BITS_OPC && l_r.opc == OPC_SECURITY_READ_CMD) begin
      so_r      <= secur_s[3'h7 - l_r.bits[2:0]];
      so_oe_n_r <= 1'b0;
    end else if (cp_s && ryby_s) begin
      so_r      <= !busy_s;
      so_oe_n_r <= 1'b0;
    end else begin
      so_r      <= 1'b1;
      so_oe_n_r <= 1'b1;
    end
  end

  assign lnk.dev_io      = {2'b00, so_r, 1'b0};
  assign lnk.dev_io_oe_n = {2'b11, so_oe_n_r, 1'b1};

  // system side: commands are decoded when cs_n rises
  always_comb begin
    logic        fend;
    logic        one;
    logic        free;
    logic        pr;
    logic [ADDR_W-1:0] nx;
    r_nxt       = r_r;
    r_nxt.cs_sy = {r_r.cs_sy[1:0], lnk.cs_n};
    r_nxt.op_v  = 1'b0;
    fend = r_r.cs_sy[1] && !r_r.cs_sy[2];
    one  = (l_r.bits == BITS_OPC);
    free = (r_r.st == ST_IDLE) && !r_r.cp;
    pr   = sfep_protected(l_r.addr, protect_level_bits_in);
    nx   = '0;
    case (r_r.st)
      ST_IDLE: begin
        if (fend) begin
          r_nxt.idx = '0;
          // timed cycle begins at cs rise
          case (l_r.opc)
            OPC_WRITE_ENABLE_CMD: if (free && one) r_nxt.write_latch = 1'b1;
            OPC_WRITE_DISABLE_CMD: if (one) begin
              r_nxt.write_latch = 1'b0;
              r_nxt.cp  = 1'b0;
            end
            OPC_BUSY_ON_OUTPUT_ON_CMD: if (free && one) r_nxt.ryby = 1'b1;
            OPC_BUSY_ON_OUTPUT_OFF_CMD: if (free && one) r_nxt.ryby = 1'b0;
            OPC_SE: if (free && r_r.write_latch && l_r.bits == BITS_ADDR && !pr) begin
              r_nxt = sfep_go(r_nxt, SFEP_OP_SECTOR, {l_r.addr[ADDR_W-1:SECTOR_LSB],
                              12'h000}, 9'h001, SE_CYC);
            end
            OPC_BE: if (free && r_r.write_latch && l_r.bits == BITS_ADDR && !pr) begin
              r_nxt = sfep_go(r_nxt, SFEP_OP_BLOCK, {l_r.addr[ADDR_W-1:BLOCK_LSB],
                              16'h0000}, 9'h001, BE_CYC);
            end
            OPC_CE: if (free && r_r.write_latch && one && protect_level_bits_in == 4'h0) begin
              r_nxt = sfep_go(r_nxt, SFEP_OP_CHIP, '0, 9'h001, CE_CYC);
            end
            OPC_PP, OPC_QPP: if (free && r_r.write_latch && l_r.bits[2:0] == 3'h0
                && l_r.bits >= BITS_PP_MIN && !pr
                && (l_r.opc == OPC_PP || quad_lines_enable_in)) begin
              r_nxt = sfep_go(r_nxt, SFEP_OP_PROG, {l_r.addr[ADDR_W-1:PAGE_LSB], 8'h00},
                              PAGE_BYTES, PP_CYC);
            end
            OPC_CP: if (r_r.write_latch) begin
              if (!r_r.cp && l_r.bits >= BITS_CP_LONG
                  && !sfep_protected({l_r.addr[ADDR_W-1:1], 1'b0}, protect_level_bits_in)) begin
                r_nxt    = sfep_go(r_nxt, SFEP_OP_PROG, {l_r.addr[ADDR_W-1:1], 1'b0},
                                   CP_BYTES, BP_CYC);
                r_nxt.cp = 1'b1;
              end else if (r_r.cp && l_r.bits >= BITS_CP_SHORT) begin
                r_nxt = sfep_go(r_nxt, SFEP_OP_PROG, r_r.base, CP_BYTES, BP_CYC);
              end
            end
            default: ;
          endcase
        end
      end
      ST_EMIT: begin
        r_nxt.op_k = r_r.kind;
        r_nxt.op_a = r_r.base;
        r_nxt.op_v = 1'b1;
        if (r_r.kind == SFEP_OP_PROG) begin
          r_nxt.op_a = r_r.base | ADDR_W'(r_r.idx[7:0]);
          r_nxt.op_v = r_r.cp || l_r.mask[r_r.idx[7:0]];
          r_nxt.op_d = r_r.cp ? (r_r.idx[0] ? l_r.d1 : l_r.d0) : pbuf[r_r.idx[7:0]];
        end
        r_nxt.idx = r_r.idx + 9'h001;
        if (r_r.idx + 9'h001 == r_r.lim) begin
          r_nxt.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        r_nxt.timer = r_r.timer - 32'h0000_0001;
        if (r_r.timer == 32'h0000_0000) begin
          r_nxt.st   = ST_IDLE;
          r_nxt.busy = 1'b0;
          if (r_r.cp) begin
            // no wrap; leave mode at area end
            nx = r_r.base + ADDR_W'(CP_BYTES);
            if (nx[ADDR_W-1:ARRAY_W] != '0 || sfep_protected(nx, protect_level_bits_in)) begin
              r_nxt.cp  = 1'b0;
              r_nxt.write_latch = 1'b0;
            end else begin
              r_nxt.base = nx;
            end
          end else begin
            r_nxt.write_latch = 1'b0;
          end
        end
      end
      default: r_nxt.st = ST_IDLE;
    endcase
  end

  function automatic sfep_ref_t sfep_go(input sfep_ref_t s, input sfep_op_t k,
                                        input logic [ADDR_W-1:0] a, input logic [8:0] n,
                                        input logic [31:0] t);
    sfep_ref_t o;
    o       = s;
    o.st    = ST_EMIT;
    o.busy  = 1'b1;
    o.kind  = k;
    o.base  = a;
    o.lim   = n;
    o.timer = t;
    return o;
  endfunction

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign op_valid_out         = r_r.op_v;
  assign op_kind_out          = r_r.op_k;
  assign op_addr_out          = r_r.op_a;
  assign op_data_out          = r_r.op_d;
  assign in_progress_flag_out = r_r.busy;
  assign write_latch_out      = r_r.write_latch;
  assign cp_mode_out          = r_r.cp;
endmodule

/* hdl/sfep_flash_host.sv */
/*
  sfep_flash_host: host end, frames one flash command per request.
  assumes the user gives write bytes when asked; sclk is divided down.
*/
`timescale 1ns/1ps
module sfep_flash_host
  import sfep_pkg::*;
(
  // system
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  // link
  sfep_if.host                   lnk,
  // request
  input  wire logic              req_valid_in,
  input  wire logic [7:0]        req_opcode_in,
  input  wire logic              req_addr_en_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic              req_quad_in,
  input  wire logic [9:0]        req_wr_len_in,
  input  wire logic [9:0]        req_rd_len_in,
  output logic                   req_ready_out,
  // write data
  output logic                   wr_data_req_out,
  input  wire logic [7:0]        wr_data_in,
  // read data and completion
  output logic                   rd_valid_out,
  output logic [7:0]             rd_data_out,
  output logic                   done_out
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LOW  = 3'b001,
    HS_HIGH = 3'b011,
    HS_DONE = 3'b010,
    HS_GAP  = 3'b110
  } sfep_hst_t;

  typedef struct packed {
    sfep_hst_t         st;
    logic [7:0]        div;
    logic              sclk;
    logic              cs_n;
    logic [3:0]        io;
    logic [3:0]        oe_n;
    logic [7:0]        sh;
    logic [2:0]        bcnt;
    logic [10:0]       bidx;
    logic [10:0]       na;
    logic [10:0]       nw;
    logic [10:0]       last;
    logic              quad;
    logic [ADDR_W-1:0] ash;
    logic [7:0]        rsh;
    logic [1:0]        sy;
    logic              rd_v;
    logic [7:0]        rd_d;
    logic              done;
    logic              wreq;
    logic              ready;
  } sfep_hreg_t;

  sfep_hreg_t h_r, h_nxt;

  always_comb begin
    logic [10:0] nb;
    logic        rd;
    logic        lanes;
    lanes      = 1'b0;
    h_nxt      = h_r;
    h_nxt.sy   = {h_r.sy[0], lnk.io[1]};
    h_nxt.rd_v = 1'b0;
    h_nxt.done = 1'b0;
    h_nxt.wreq = 1'b0;
    nb   = h_r.bidx + 11'h001;
    rd   = h_r.bidx > h_r.na + h_r.nw;
    case (h_r.st)
      HS_IDLE: begin
        h_nxt.ready = 1'b1;
        if (req_valid_in && h_r.ready) begin
          h_nxt.ready = 1'b0;
          h_nxt.cs_n  = 1'b0;
          h_nxt.sh    = req_opcode_in;
          h_nxt.bcnt  = 3'h7;
          h_nxt.bidx  = '0;
          h_nxt.na    = req_addr_en_in ? 11'h003 : 11'h000;
          h_nxt.nw    = 11'(req_wr_len_in);
          h_nxt.last  = (req_addr_en_in ? 11'h003 : 11'h000) + 11'(req_wr_len_in)
                        + 11'(req_rd_len_in);
          h_nxt.quad  = req_quad_in;
          h_nxt.ash   = req_addr_in;
          h_nxt.div   = SCLK_HALF_CYC - 8'h01;
          h_nxt.st    = HS_LOW;
        end
      end
      HS_LOW: begin
        h_nxt.div = h_r.div - 8'h01;
        if (h_r.div == 8'h00) begin
          h_nxt.sclk = 1'b1;
          h_nxt.div  = SCLK_HALF_CYC - 8'h01;
          h_nxt.st   = HS_HIGH;
        end
      end
      HS_HIGH: begin
        h_nxt.div = h_r.div - 8'h01;
        if (h_r.div == 8'h01 && h_r.bcnt == 3'h0 && nb > h_r.na && nb <= h_r.na + h_r.nw) begin
          h_nxt.wreq = 1'b1;
        end
        if (h_r.div == 8'h00) begin
          h_nxt.sclk = 1'b0;
          h_nxt.div  = SCLK_HALF_CYC - 8'h01;
          h_nxt.st   = HS_LOW;
          h_nxt.rsh  = {h_r.rsh[6:0], h_r.sy[1]};
          lanes      = h_r.quad && h_r.bidx != 11'h000;
          h_nxt.sh   = lanes ? {h_r.sh[3:0], 4'h0} : {h_r.sh[6:0], 1'b0};
          h_nxt.bcnt = h_r.bcnt - 3'h1;
          if (h_r.bcnt == 3'h0) begin
            h_nxt.rd_v = rd;
            h_nxt.rd_d = {h_r.rsh[6:0], h_r.sy[1]};
            if (h_r.bidx == h_r.last) begin
              h_nxt.st = HS_DONE;
            end else begin
              h_nxt.bidx = nb;
              // quad requests send address and data four lines wide
              h_nxt.bcnt = h_r.quad ? 3'h1 : 3'h7;
              if (nb <= h_r.na) begin
                h_nxt.sh  = h_r.ash[ADDR_W-1 -: 8];
                h_nxt.ash = {h_r.ash[ADDR_W-9:0], 8'h00};
              end else if (nb <= h_r.na + h_r.nw) begin
                h_nxt.sh = wr_data_in;
              end else begin
                h_nxt.sh = 8'h00;
              end
            end
          end
        end
      end
      HS_DONE: begin
        h_nxt.div = h_r.div - 8'h01;
        if (h_r.div == 8'h00) begin
          // cs rises half a clock after the last whole byte
          h_nxt.cs_n = 1'b1;
          h_nxt.div  = SCLK_HALF_CYC - 8'h01;
          h_nxt.st   = HS_GAP;
        end
      end
      HS_GAP: begin
        h_nxt.div = h_r.div - 8'h01;
        if (h_r.div == 8'h00) begin
          h_nxt.done = 1'b1;
          h_nxt.st   = HS_IDLE;
        end
      end
      default: h_nxt.st = HS_IDLE;
    endcase
    // pin drive from the next shift state
    rd          = h_nxt.bidx > h_nxt.na + h_nxt.nw;
    lanes       = h_nxt.quad && h_nxt.bidx != 11'h000;
    h_nxt.io    = lanes ? h_nxt.sh[7:4] : {3'b000, h_nxt.sh[7]};
    h_nxt.oe_n  = (h_nxt.cs_n || rd) ? 4'hF : (lanes ? 4'h0 : 4'hE);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      h_r      <= '0;
      h_r.cs_n <= 1'b1;
      h_r.oe_n <= 4'hF;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign lnk.cs_n         = h_r.cs_n;
  assign lnk.sclk         = h_r.sclk;
  assign lnk.host_io      = h_r.io;
  assign lnk.host_io_oe_n = h_r.oe_n;
  assign req_ready_out    = h_r.ready;
  assign wr_data_req_out  = h_r.wreq;
  assign rd_valid_out     = h_r.rd_v;
  assign rd_data_out      = h_r.rd_d;
  assign done_out         = h_r.done;
endmodule

/* sim/sfep_link_sva.sv */
/* sfep_link_sva: checks on the flash link wires.
   assumes the bench places it beside the link. */
`timescale 1ns/1ps
module sfep_link_sva (
  // system
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  // link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io,
  input wire logic [3:0] host_io_oe_n,
  input wire logic [3:0] dev_io_oe_n
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_dev_idle_off: assert property (cs_n && $past(cs_n) |-> &dev_io_oe_n)
    else $error("device drives while idle");
  a_dev_line_one: assert property (&{dev_io_oe_n[3:2], dev_io_oe_n[0]})
    else $error("device drives a data line");
  a_no_fight: assert property (!(|(~dev_io_oe_n & ~host_io_oe_n)))
    else $error("both ends drive");
  a_idle_clk_low: assert property (cs_n |-> !sclk)
    else $error("clock runs while idle");
  a_cs_gap: assert property ($rose(cs_n) |=> cs_n [*7])
    else $error("frame gap short");
  a_clk_high_half: assert property ($rose(sclk) |=> sclk [*8])
    else $error("clock high too short");
  a_clk_low_half: assert property ($fell(sclk) |=> !sclk [*8])
    else $error("clock low too short");
  a_data_steady: assert property (sclk && $past(sclk) |-> $stable(host_io))
    else $error("data moves while clock high");
  c_frame: cover property ($rose(cs_n));
  c_quad: cover property (!host_io_oe_n[3]);
  c_dev_drive: cover property (!dev_io_oe_n[1]);
endmodule

/* sim/serial_flash_erase_program_tb.sv */
/* serial_flash_erase_program_tb: host and device ends on one link.
   assumes short cycle counts on the device instance. */
`timescale 1ns/1ps
module serial_flash_erase_program_tb;
  import sfep_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        rv = 1'b0, ae = 1'b0, rq = 1'b0, qe = 1'b0, seen = 1'b0;
  logic [7:0]  ro = 8'h00, wd [4];
  logic [23:0] ra = 24'h0000, a, b;
  logic [9:0]  rw = 10'h000;
  logic [3:0]  prot = 4'h0;
  logic [31:0] lfsr = 32'h5d1e;
  logic [1:0]  wi = 2'h0;
  logic        rdy, wreq, done, opv, flag, write_latch, cp;
  sfep_op_t    kind;
  logic [23:0] oa;
  logic [7:0]  od;
  logic [33:0] ops [$];
  int          n_mismatch = 0;
  int          n_checks   = 0;
  sfep_if lnk ();
  sfep_flash_host i_sfep_flash_host (.ref_clk_in, .rst_in, .lnk(lnk), .req_valid_in(rv),
    .req_opcode_in(ro), .req_addr_en_in(ae), .req_addr_in(ra), .req_quad_in(rq),
    .req_wr_len_in(rw), .req_rd_len_in(10'h000), .req_ready_out(rdy), .wr_data_req_out(wreq),
    .wr_data_in(wd[wi]), .rd_valid_out(), .rd_data_out(), .done_out(done));
  sfep_flash_dev #(.SE_CYC(32'h0000_00c8), .BE_CYC(32'h0000_012c), .CE_CYC(32'h0000_0190),
    .PP_CYC(32'h0000_0064)) i_sfep_flash_dev (.ref_clk_in, .rst_in, .lnk(lnk),
    .protect_level_bits_in(prot), .quad_lines_enable_in(qe), .op_valid_out(opv),
    .op_kind_out(kind), .op_addr_out(oa), .op_data_out(od), .in_progress_flag_out(flag),
    .write_latch_out(write_latch), .cp_mode_out(cp));
  sfep_link_sva i_sfep_link_sva (.ref_clk_in, .rst_in, .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .host_io(lnk.host_io), .host_io_oe_n(lnk.host_io_oe_n), .dev_io_oe_n(lnk.dev_io_oe_n));
  initial forever #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    if (wreq) wi <= wi + 2'h1;
    if (flag) seen <= 1'b1;
    if (opv) ops.push_back({kind, oa, kind == SFEP_OP_PROG ? od : 8'h00});
  end
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [33:0] op(sfep_op_t k, logic [23:0] d_a, logic [7:0] d);
    return {k, d_a, d};
  endfunction
  task automatic complete_run;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(logic [33:0] g, logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic waitc(int sel, int lim);
    for (int t = 0; !(sel == 0 ? rdy : sel == 1 ? done : !flag); t++) begin
      if (t > lim) begin
        n_mismatch++;
        $display("mismatch %0t wait ran out", $time);
        complete_run();
      end
      @(posedge ref_clk_in);
      #1;
    end
  endtask
  task automatic send(logic [7:0] o, logic e, logic [23:0] d_a, logic q, logic [9:0] n);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wd[i] = lfsr[7:0];
    end
    ops.delete();
    wi = 2'h0;
    seen = 1'b0;
    waitc(0, 1000);
    @(posedge ref_clk_in);
    rv <= 1'b1;
    ro <= o;
    ae <= e;
    ra <= d_a;
    rq <= q;
    rw <= n;
    @(posedge ref_clk_in);
    rv <= 1'b0;
    waitc(1, 20000);
    repeat (12) @(posedge ref_clk_in);
    waitc(2, 5000);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    a = {3'h0, lfsr[20:0]};
    b = {4'h0, a[19:0]};
    send(DEF_OPC_SE, 1'b1, a, 1'b0, 10'h000);
    cmp(34'(ops.size()), 34'h0);
    send(DEF_OPC_WRITE_ENABLE_CMD, 1'b0, a, 1'b0, 10'h000);
    cmp(34'(write_latch), 34'h1);
    send(DEF_OPC_SE, 1'b1, a, 1'b0, 10'h000);
    cmp(ops[0], op(SFEP_OP_SECTOR, {a[23:12], 12'h000}, 8'h00));
    cmp(34'({ops.size(), seen, write_latch}), 34'h6);
    prot <= 4'h1;
    send(DEF_OPC_WRITE_ENABLE_CMD, 1'b0, a, 1'b0, 10'h000);
    send(DEF_OPC_BE, 1'b1, {3'h0, 5'h1f, a[15:0]}, 1'b0, 10'h000);
    cmp(34'({ops.size(), write_latch}), 34'h1);
    send(DEF_OPC_BE, 1'b1, b, 1'b0, 10'h000);
    cmp(ops[0], op(SFEP_OP_BLOCK, {b[23:16], 16'h0000}, 8'h00));
    send(DEF_OPC_WRITE_ENABLE_CMD, 1'b0, a, 1'b0, 10'h000);
    send(DEF_OPC_CE, 1'b0, a, 1'b0, 10'h000);
    cmp(34'(ops.size()), 34'h0);
    prot <= 4'h0;
    send(DEF_OPC_CE, 1'b0, a, 1'b0, 10'h000);
    cmp(ops[0], op(SFEP_OP_CHIP, 24'h0000, 8'h00));
    cmp(34'({seen, write_latch}), 34'h2);
    send(DEF_OPC_WRITE_ENABLE_CMD, 1'b0, a, 1'b0, 10'h000);
    b = {a[23:8], 8'hfe};
    send(DEF_OPC_PP, 1'b1, b, 1'b0, 10'h003);
    cmp(34'(ops.size()), 34'h3);
    cmp(ops[0], op(SFEP_OP_PROG, {b[23:8], 8'h00}, wd[2]));
    cmp(ops[1], op(SFEP_OP_PROG, b, wd[0]));
    cmp(ops[2], op(SFEP_OP_PROG, {b[23:8], 8'hff}, wd[1]));
    send(DEF_OPC_WRITE_ENABLE_CMD, 1'b0, a, 1'b0, 10'h000);
    send(DEF_OPC_QPP, 1'b1, b, 1'b1, 10'h001);
    cmp(34'({ops.size(), write_latch}), 34'h1);
    qe <= 1'b1;
    send(DEF_OPC_QPP, 1'b1, b, 1'b1, 10'h001);
    cmp(ops[0], op(SFEP_OP_PROG, b, wd[0]));
    send(DEF_OPC_WRITE_ENABLE_CMD, 1'b0, a, 1'b0, 10'h000);
    b = {a[23:1], 1'b1};
    send(OPC_CP, 1'b1, b, 1'b0, 10'h002);
    cmp(ops[0], op(SFEP_OP_PROG, {b[23:1], 1'b0}, wd[0]));
    cmp(ops[1], op(SFEP_OP_PROG, b, wd[1]));
    send(OPC_CP, 1'b0, b, 1'b0, 10'h001);
    cmp(34'({ops.size(), cp}), 34'h1);
    send(OPC_WRITE_DISABLE_CMD, 1'b0, a, 1'b0, 10'h000);
    cmp(34'({cp, write_latch}), 34'h0);
    complete_run();
  end
endmodule
